// File: hw/pbi_pkg.sv
/*
 * Shared constants for the special-function input block: time bases,
 * timing counts, analogue scaling limits and reset values.
 * Assumes a 100 MHz program clock; all counts derive from that rate.
 */
package pbi_pkg;
	// Clock and timing figures in their own units
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_CYCLE_NS = 1000000;
	localparam int HUNDREDTH_NS = 10000000;
	localparam int PROG_CYCLE_CYC = (PROG_CYCLE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int HUNDREDTH_CYC = HUNDREDTH_NS / CLK_PERIOD_NS;
	localparam int DIV_W = 20;

	// Time base encodings on the base select port
	localparam logic [1:0] BASE_SEC = 2'h0;
	localparam logic [1:0] BASE_MIN = 2'h1;
	localparam logic [1:0] BASE_HOUR = 2'h2;

	// Hundredths of a second per step of the low time field, then time field radix and limits
	localparam logic [12:0] UNIT_SEC = 13'h0001;
	localparam logic [12:0] UNIT_MIN = 13'h0064;
	localparam logic [12:0] UNIT_HOUR = 13'h1770;
	localparam logic [6:0] HI_RADIX = 7'h64;
	localparam logic [6:0] LO_MAX_SEC = 7'h63;
	localparam logic [6:0] LO_MAX_MIN = 7'h3B;
	localparam logic [6:0] HI_MAX = 7'h63;

	// Frequency gate length in hundredths (one second)
	localparam logic [6:0] FREQ_GATE_HS = 7'h64;

	// Analogue converter codes and scaling limits
	localparam logic [11:0] AIN_FULL_CODE = 12'hFA0;
	localparam logic [11:0] AIN_4MA_CODE = 12'h320;
	localparam logic [10:0] INT_MAX = 11'h3E8;
	localparam logic signed [10:0] GAIN_MIN = -11'sh3E8;
	localparam logic signed [10:0] GAIN_MAX = 11'sh3E8;
	localparam logic signed [14:0] OFFS_MIN = -15'sh2710;
	localparam logic signed [14:0] OFFS_MAX = 15'sh2710;
	localparam logic signed [23:0] GAIN_SCALE = 24'sh000064;

	// Reset values of the parameter store and the pulse counter
	localparam logic signed [10:0] GAIN_RST = 11'sh064;
	localparam logic signed [14:0] OFFS_RST = 15'sh0000;
	localparam logic [6:0] TIME_RST = 7'h00;
	localparam logic [15:0] COUNT_RST = 16'h0000;

	typedef enum logic [1:0] {PBI_TMR_IDLE, PBI_TMR_RUN, PBI_TMR_DONE}
		pbi_tmr_t;
endpackage

// File: hw/pbi_core.sv
/*
 * Special-function block core: set/reset/trigger/count/direction/
 * frequency/enable/invert/clear-all inputs, on-delay timer with three
 * time bases, retention over power loss, parameter protection and the
 * analogue input scaling path.
 * Assumes all inputs synchronous to mclk; powerOk low means supply lost.
 */
`timescale 1ns/1ps
module pbi_core import pbi_pkg::*; #(
	parameter int unsigned PROG_CYC = PROG_CYCLE_CYC,
	parameter int unsigned HS_CYC = HUNDREDTH_CYC
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic powerOk,
	input wire logic setIn,
	input wire logic rstIn,
	input wire logic trgIn,
	input wire logic cntIn,
	input wire logic dirUp,
	input wire logic freIn,
	input wire logic enIn,
	input wire logic invIn,
	input wire logic clrIn,
	input wire logic retentive,
	input wire logic alwaysRetain,
	input wire logic paramProtect,
	input wire logic paramLoad,
	input wire logic paramFromTool,
	input wire logic [1:0] paramBase,
	input wire logic [6:0] paramHi,
	input wire logic [6:0] paramLo,
	input wire logic signed [10:0] paramGain,
	input wire logic signed [14:0] paramOffset,
	input wire logic currentMode,
	input wire logic liveZero4mA,
	input wire logic [11:0] analogue_input_terminal,
	output logic qOut_r,
	output logic [15:0] countValue_r,
	output logic [15:0] freqValue_r,
	output logic timerBusy_r,
	output logic [10:0] ainInternal_r,
	output logic signed [16:0] scaled_analogue_value_r,
	output logic paramHidden_r,
	output logic paramRejected_r
);

	// Rising edge between the last two program-cycle samples
	function automatic logic rose(input logic now, input logic prev);
		return now & ~prev;
	endfunction

	// Total steps of the time parameter for the chosen base
	function automatic logic [13:0] stepsOf(input logic [1:0] b,
		input logic [6:0] hi, input logic [6:0] lo);
		logic [13:0] r;
		r = 14'h0000;
		if (b == BASE_SEC)
			r = 14'(hi * HI_RADIX) + 14'(lo);
		else
			r = 14'(hi * 7'h3C) + 14'(lo);
		return r;
	endfunction

	// Hundredths per step for the chosen base
	function automatic logic [12:0] unitOf(input logic [1:0] b);
		logic [12:0] u;
		u = UNIT_SEC;
		case (b)
			BASE_MIN: u = UNIT_MIN;
			BASE_HOUR: u = UNIT_HOUR;
			default: u = UNIT_SEC;
		endcase
		return u;
	endfunction

	logic [DIV_W-1:0] progCnt_r;
	logic [DIV_W-1:0] hsCnt_r;
	logic cycleTick_r;
	logic hsTick_r;
	logic pwrPrev_r;
	logic runOk_r;
	logic trgPrev_r, cntPrev_r, frePrev_r;
	logic qState_r;
	pbi_tmr_t tmrState_r;
	logic [13:0] remain_r;
	logic [12:0] unit_r;
	logic [12:0] unitLen_r;
	logic [6:0] gateCnt_r;
	logic [15:0] edgeCnt_r;
	logic [1:0] base_r;
	logic [6:0] timeHi_r, timeLo_r;
	logic signed [10:0] gain_r;
	logic signed [14:0] offset_r;

	logic wipe, doRst, doClr, doRun, timerStart, expire, paramOk, freEdge;
	logic [13:0] startSteps;

	// Power return wipes state unless retention holds it
	assign wipe = powerOk & ~pwrPrev_r & ~(retentive | alwaysRetain);
	assign doRst = cycleTick_r & rstIn;
	assign doClr = cycleTick_r & ~rstIn & enIn & clrIn;
	assign doRun = cycleTick_r & ~rstIn & enIn & ~clrIn;
	assign startSteps = stepsOf(base_r, timeHi_r, timeLo_r);
	assign timerStart = doRun & rose(trgIn, trgPrev_r);
	assign freEdge = doRun & rose(freIn, frePrev_r);
	assign expire = (tmrState_r == PBI_TMR_RUN) & hsTick_r & runOk_r
		& (unit_r == 13'h0000) & (remain_r == 14'h0001);

	// Program-cycle divider; stops while supply is lost
	always_ff @(posedge mclk) begin
		if (srst || !powerOk) begin
			progCnt_r <= '0;
			cycleTick_r <= 1'b0;
		end else if (progCnt_r == DIV_W'(PROG_CYC - 1)) begin
			progCnt_r <= '0;
			cycleTick_r <= 1'b1;
		end else begin
			progCnt_r <= progCnt_r + 1'b1;
			cycleTick_r <= 1'b0;
		end
	end

	// Hundredth divider restarts on trigger so phase adds no error
	always_ff @(posedge mclk) begin
		if (srst || !powerOk || timerStart) begin
			hsCnt_r <= '0;
			hsTick_r <= 1'b0;
		end else if (hsCnt_r == DIV_W'(HS_CYC - 1)) begin
			hsCnt_r <= '0;
			hsTick_r <= 1'b1;
		end else begin
			hsCnt_r <= hsCnt_r + 1'b1;
			hsTick_r <= 1'b0;
		end
	end

	// Input history and per-cycle run permission
	always_ff @(posedge mclk) begin
		if (srst) begin
			pwrPrev_r <= 1'b0;
			runOk_r <= 1'b0;
			trgPrev_r <= 1'b0;
			cntPrev_r <= 1'b0;
			frePrev_r <= 1'b0;
		end else begin
			pwrPrev_r <= powerOk;
			if (cycleTick_r) begin
				runOk_r <= enIn & ~rstIn & ~clrIn;
				trgPrev_r <= trgIn;
				cntPrev_r <= cntIn;
				frePrev_r <= freIn;
			end
		end
	end

	// Switching state of the block
	always_ff @(posedge mclk) begin
		if (srst || wipe || doRst || doClr)
			qState_r <= 1'b0;
		else if (doRun && setIn)
			qState_r <= 1'b1;
		else if (expire)
			qState_r <= 1'b1;
	end

	// Output refresh once per cycle; held while disabled, but the reset input still clears it
	always_ff @(posedge mclk) begin
		if (srst || doRst)
			qOut_r <= 1'b0;
		else if (cycleTick_r && enIn)
			qOut_r <= qState_r ^ invIn;
	end

	// On-delay timer; frozen with the dividers during power loss
	always_ff @(posedge mclk) begin
		if (srst || wipe || doRst || doClr) begin
			tmrState_r <= PBI_TMR_IDLE;
			remain_r <= '0;
			unit_r <= '0;
			unitLen_r <= UNIT_SEC;
			timerBusy_r <= 1'b0;
		end else if (timerStart) begin
			unitLen_r <= unitOf(base_r);
			unit_r <= unitOf(base_r) - 13'h0001;
			remain_r <= startSteps;
			if (startSteps == 14'h0000) begin
				tmrState_r <= PBI_TMR_DONE;
				timerBusy_r <= 1'b0;
			end else begin
				tmrState_r <= PBI_TMR_RUN;
				timerBusy_r <= 1'b1;
			end
		end else begin
			case (tmrState_r)
				PBI_TMR_RUN: begin
					if (hsTick_r && runOk_r) begin
						if (unit_r != 13'h0000) begin
							unit_r <= unit_r - 13'h0001;
						end else if (remain_r == 14'h0001) begin
							remain_r <= '0;
							tmrState_r <= PBI_TMR_DONE;
							timerBusy_r <= 1'b0;
						end else begin
							remain_r <= remain_r - 14'h0001;
							unit_r <= unitLen_r - 13'h0001;
						end
					end
				end
				PBI_TMR_DONE: tmrState_r <= PBI_TMR_DONE;
				default: tmrState_r <= PBI_TMR_IDLE;
			endcase
		end
	end

	// Up/down pulse counter; wraps at the 16-bit limits
	always_ff @(posedge mclk) begin
		if (srst || wipe || doRst || doClr)
			countValue_r <= COUNT_RST;
		else if (doRun && rose(cntIn, cntPrev_r)) begin
			if (dirUp)
				countValue_r <= countValue_r + 16'h0001;
			else
				countValue_r <= countValue_r - 16'h0001;
		end
	end

	// Edges per one-second gate; an edge on the closing clock still counts
	always_ff @(posedge mclk) begin
		if (srst || wipe || doRst || doClr) begin
			gateCnt_r <= '0;
			edgeCnt_r <= '0;
			freqValue_r <= '0;
		end else begin
			if (hsTick_r && gateCnt_r == FREQ_GATE_HS - 7'h01) begin
				gateCnt_r <= '0;
				freqValue_r <= edgeCnt_r + {15'h0000, freEdge};
				edgeCnt_r <= '0;
			end else begin
				if (hsTick_r)
					gateCnt_r <= gateCnt_r + 7'h01;
				if (freEdge)
					edgeCnt_r <= edgeCnt_r + 16'h0001;
			end
		end
	end

	// Parameter store; protection blocks the panel but not the tool
	assign paramOk = (!paramProtect || paramFromTool)
		&& paramHi <= HI_MAX
		&& paramBase != 2'h3
		&& paramLo <= ((paramBase == BASE_SEC) ? LO_MAX_SEC : LO_MAX_MIN)
		&& paramGain >= GAIN_MIN && paramGain <= GAIN_MAX
		&& paramOffset >= OFFS_MIN && paramOffset <= OFFS_MAX;

	always_ff @(posedge mclk) begin
		if (srst) begin
			base_r <= BASE_SEC;
			timeHi_r <= TIME_RST;
			timeLo_r <= TIME_RST;
			gain_r <= GAIN_RST;
			offset_r <= OFFS_RST;
			paramRejected_r <= 1'b0;
			paramHidden_r <= 1'b0;
		end else begin
			paramHidden_r <= paramProtect;
			paramRejected_r <= paramLoad & ~paramOk;
			if (paramLoad && paramOk) begin
				base_r <= paramBase;
				timeHi_r <= paramHi;
				timeLo_r <= paramLo;
				gain_r <= paramGain;
				offset_r <= paramOffset;
			end
		end
	end

	// Analogue conversion to 0..1000, then gain and offset
	logic [11:0] ainBase, ainSpan, ainDiff;
	logic [22:0] ainProd;
	logic [10:0] ainInt;
	logic signed [23:0] gainProd;
	logic signed [23:0] scaledWide;

	always_comb begin
		ainBase = (currentMode && liveZero4mA) ? AIN_4MA_CODE : 12'h000;
		ainSpan = AIN_FULL_CODE - ainBase;
		ainDiff = (analogue_input_terminal > ainBase)
			? analogue_input_terminal - ainBase : 12'h000;
		ainProd = 23'(ainDiff) * 23'(INT_MAX);
		if (ainDiff >= ainSpan)
			ainInt = INT_MAX;
		else
			ainInt = 11'(ainProd / 23'(ainSpan));
		gainProd = $signed({13'h0000, ainInt}) * 24'(gain_r);
		scaledWide = gainProd / GAIN_SCALE + 24'(offset_r);
	end

	// Analogue results refresh once per program cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			ainInternal_r <= '0;
			scaled_analogue_value_r <= '0;
		end else if (cycleTick_r) begin
			ainInternal_r <= ainInt;
			scaled_analogue_value_r <= scaledWide[16:0];
		end
	end

	property p_reset_clears;
		@(posedge mclk) disable iff (srst)
		(cycleTick_r && rstIn) |=> (!qOut_r && !qState_r && !timerBusy_r);
	endproperty
	a_reset_clears: assert property (p_reset_clears)
		else $error("reset input did not clear the block");

	property p_set_output;
		@(posedge mclk) disable iff (srst)
		(doRun && setIn && powerOk) |=> qState_r;
	endproperty
	a_set_output: assert property (p_set_output)
		else $error("set input did not drive state to one");

	property p_enable_hold;
		@(posedge mclk) disable iff (srst)
		(cycleTick_r && !enIn && !rstIn && !wipe) |=> $stable(countValue_r);
	endproperty
	a_enable_hold: assert property (p_enable_hold)
		else $error("count moved while block disabled");

	property p_count_dir;
		@(posedge mclk) disable iff (srst)
		(doRun && cntIn && !cntPrev_r && !wipe) |=>
		countValue_r == (($past(dirUp)) ? $past(countValue_r) + 16'h0001
			: $past(countValue_r) - 16'h0001);
	endproperty
	a_count_dir: assert property (p_count_dir)
		else $error("count step wrong for direction");

	property p_invert;
		@(posedge mclk) disable iff (srst)
		(cycleTick_r && enIn && !rstIn) |=>
		qOut_r == ($past(qState_r) ^ $past(invIn));
	endproperty
	a_invert: assert property (p_invert)
		else $error("output polarity does not follow invert");

	property p_clear_all;
		@(posedge mclk) disable iff (srst)
		doClr |=> (countValue_r == 16'h0000 && freqValue_r == 16'h0000
			&& tmrState_r == PBI_TMR_IDLE);
	endproperty
	a_clear_all: assert property (p_clear_all)
		else $error("clear-all left internal values");

	property p_saturate;
		@(posedge mclk) disable iff (srst)
		(cycleTick_r && analogue_input_terminal >= AIN_FULL_CODE)
		|=> ainInternal_r == INT_MAX;
	endproperty
	a_saturate: assert property (p_saturate)
		else $error("full-scale input not at 1000");

	property p_protect;
		@(posedge mclk) disable iff (srst)
		(paramLoad && paramProtect && !paramFromTool) |=>
		($stable(gain_r) && $stable(offset_r) && paramRejected_r);
	endproperty
	a_protect: assert property (p_protect)
		else $error("protected parameter changed from panel");

	property p_retain_timer;
		@(posedge mclk) disable iff (srst)
		(powerOk && !pwrPrev_r && (retentive || alwaysRetain))
		|-> ##1 $stable(remain_r);
	endproperty
	a_retain_timer: assert property (p_retain_timer)
		else $error("retentive timer disturbed on power return");

endmodule // pbi_core

// File: verification/pbi_terminal.sv
/*
 * Stand-in for the analogue input terminal and its converter.
 * Assumes a 10 V full scale giving code 4000, and one program clock.
 */
`timescale 1ns/1ps
module pbi_terminal (
	input wire logic mclk,
	input wire logic [15:0] milliVolts,
	output logic [11:0] code
);
	// Linear 0..10 V to 0..4000; above range pins the converter at top
	always_ff @(posedge mclk) begin
		if (milliVolts > 16'h2710) begin
			code <= 12'hFFF;
		end else begin
			code <= 12'(32'(milliVolts) * 2 / 5);
		end
	end
endmodule // pbi_terminal

// File: verification/test_pbi_core.sv
/*
 * Self-checking bench for the special-function block core.
 * Assumes PROG_CYC=10 and HS_CYC=20, so one program cycle is 10 clocks.
 */
`timescale 1ns/1ps
module test_pbi_core import pbi_pkg::*;;
	logic mclk, srst, powerOk, setIn, rstIn, trgIn, cntIn, dirUp, freIn;
	logic enIn, invIn, clrIn, retentive, paramProtect, paramLoad;
	logic paramFromTool;
	logic alwaysRetain, currentMode, liveZero4mA;
	logic [1:0] paramBase;
	logic [6:0] paramHi, paramLo;
	logic signed [10:0] paramGain;
	logic signed [14:0] paramOffset;
	logic [15:0] milliVolts;
	logic [11:0] ainCode;
	logic qOut, timerBusy, paramHidden, paramRejected;
	logic [15:0] countValue, freqValue;
	logic [10:0] ainInternal;
	logic signed [16:0] scaledValue;
	int miscompares, check_count, expCount, expAin, gain, offs;
	bit [31:0] rnd;

	pbi_core #(.PROG_CYC(10), .HS_CYC(20)) i_pbi_core (.mclk(mclk),
		.srst(srst), .powerOk(powerOk), .setIn(setIn), .rstIn(rstIn),
		.trgIn(trgIn), .cntIn(cntIn), .dirUp(dirUp), .freIn(freIn),
		.enIn(enIn), .invIn(invIn), .clrIn(clrIn), .retentive(retentive),
		.alwaysRetain(alwaysRetain), .paramProtect(paramProtect),
		.paramLoad(paramLoad), .paramFromTool(paramFromTool),
		.paramBase(paramBase), .paramHi(paramHi), .paramLo(paramLo),
		.paramGain(paramGain), .paramOffset(paramOffset),
		.currentMode(currentMode), .liveZero4mA(liveZero4mA),
		.analogue_input_terminal(ainCode), .qOut_r(qOut),
		.countValue_r(countValue), .freqValue_r(freqValue),
		.timerBusy_r(timerBusy), .ainInternal_r(ainInternal),
		.scaled_analogue_value_r(scaledValue), .paramHidden_r(paramHidden),
		.paramRejected_r(paramRejected));
	pbi_terminal i_pbi_terminal (.mclk(mclk), .milliVolts(milliVolts),
		.code(ainCode));

	// Free-running program clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	function automatic bit [31:0] xorshift(input bit [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic give_verdict();
		if (miscompares == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(string what, logic [16:0] exp, logic [16:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// Waits whole program cycles, leaving inputs just after an edge
	task automatic wt(int n);
		repeat (n * 10) @(posedge mclk);
		#1;
	endtask

	// Edge needs a low sample and a high sample, so two cycles each
	task automatic pulseCnt();
		cntIn = 1'b1;
		wt(2);
		cntIn = 1'b0;
		wt(2);
	endtask

	task automatic loadParam(int g, int o, logic tool);
		paramGain = 11'(g);
		paramOffset = 15'(o);
		paramFromTool = tool;
		paramLoad = 1'b1;
		@(posedge mclk);
		#1;
		paramLoad = 1'b0;
	endtask

	// Hang guard: the whole sequence needs far fewer clocks
	initial begin
		repeat (30000) @(posedge mclk);
		miscompares++;
		give_verdict();
	end

	initial begin
		{setIn, rstIn, trgIn, cntIn, freIn, invIn, clrIn} = '0;
		{retentive, paramProtect, paramLoad, paramFromTool} = '0;
		{alwaysRetain, currentMode, liveZero4mA} = '0;
		{srst, powerOk, enIn, dirUp} = 4'hF;
		paramBase = BASE_SEC;
		paramHi = 7'h00;
		paramLo = 7'h02;
		paramGain = 11'sh064;
		paramOffset = 15'sh0000;
		milliVolts = 16'h0000;
		miscompares = 0;
		check_count = 0;
		expCount = 0;
		rnd = 32'h7541;
		repeat (3) @(posedge mclk);
		#1;
		srst = 1'b0;
		chk("qOut", 17'h0, 17'(qOut));
		chk("count", 17'h0, 17'(countValue));
		// Up three, down one, then a pulse while disabled
		repeat (3) pulseCnt();
		expCount = 3;
		chk("count", 17'(expCount), 17'(countValue));
		dirUp = 1'b0;
		pulseCnt();
		expCount--;
		chk("count", 17'(expCount), 17'(countValue));
		enIn = 1'b0;
		pulseCnt();
		chk("count", 17'(expCount), 17'(countValue));
		// Power loss keeps state when retentive is set
		retentive = 1'b1;
		enIn = 1'b1;
		powerOk = 1'b0;
		wt(1);
		powerOk = 1'b1;
		wt(2);
		chk("count", 17'(expCount), 17'(countValue));
		// An always-retentive class ignores the retention setting
		retentive = 1'b0;
		alwaysRetain = 1'b1;
		powerOk = 1'b0;
		wt(1);
		powerOk = 1'b1;
		wt(2);
		chk("count", 17'(expCount), 17'(countValue));
		alwaysRetain = 1'b0;
		powerOk = 1'b0;
		wt(1);
		powerOk = 1'b1;
		wt(2);
		chk("count", 17'h0, 17'(countValue));
		// Set ignored while disabled, then seen, inverted, overridden
		enIn = 1'b0;
		setIn = 1'b1;
		wt(3);
		chk("qOut", 17'h0, 17'(qOut));
		enIn = 1'b1;
		wt(3);
		chk("qOut", 17'h1, 17'(qOut));
		invIn = 1'b1;
		wt(3);
		chk("qOut", 17'h0, 17'(qOut));
		invIn = 1'b0;
		rstIn = 1'b1;
		wt(3);
		chk("qOut", 17'h0, 17'(qOut));
		{setIn, rstIn} = 2'b00;
		wt(2);
		// Two hundredths on the seconds base, 40 clocks
		loadParam(100, 0, 1'b0);
		trgIn = 1'b1;
		wt(2);
		chk("busy", 17'h1, 17'(timerBusy));
		wt(6);
		chk("busy", 17'h0, 17'(timerBusy));
		chk("qOut", 17'h1, 17'(qOut));
		trgIn = 1'b0;
		clrIn = 1'b1;
		wt(3);
		chk("qOut", 17'h0, 17'(qOut));
		clrIn = 1'b0;
		// One rising edge per 20 clocks against a 2000-clock gate
		repeat (205) begin
			freIn = 1'b1;
			wt(1);
			freIn = 1'b0;
			wt(1);
		end
		chk("freq", 17'h64, 17'(freqValue));
		// One second on the minutes base: 100 hundredths, 2000 clocks
		paramBase = BASE_MIN;
		paramLo = 7'h01;
		loadParam(100, 0, 1'b0);
		trgIn = 1'b1;
		wt(1);
		chk("busy", 17'h1, 17'(timerBusy));
		wt(195);
		chk("busy", 17'h1, 17'(timerBusy));
		wt(10);
		chk("busy", 17'h0, 17'(timerBusy));
		chk("qOut", 17'h1, 17'(qOut));
		trgIn = 1'b0;
		// Random scaling, limits of gain first; 15000 mV is over range
		for (int k = 0; k < 8; k++) begin
			rnd = xorshift(rnd);
			expAin = (k == 2) ? 1000 : int'(rnd % 1001);
			milliVolts = (k == 2) ? 16'h3A98 : 16'(expAin * 10);
			rnd = xorshift(rnd);
			gain = (k == 0) ? -1000 : (k == 1) ? 1000
				: int'(rnd % 2001) - 1000;
			offs = int'((rnd >> 12) % 20001) - 10000;
			loadParam(gain, offs, 1'b1);
			wt(3);
			chk("ain", 17'(expAin), 17'(ainInternal));
			chk("scaled", 17'(expAin * gain / 100 + offs),
				17'(scaledValue));
		end
		// Protected store refuses a panel write and an out-of-range gain
		paramProtect = 1'b1;
		loadParam(5, 0, 1'b0);
		chk("rejected", 17'h1, 17'(paramRejected));
		chk("hidden", 17'h1, 17'(paramHidden));
		wt(1);
		loadParam(1001, 0, 1'b1);
		chk("rejected", 17'h1, 17'(paramRejected));
		wt(3);
		chk("scaled", 17'(expAin * gain / 100 + offs),
			17'(scaledValue));
		// Tool may still write; 12 mA is midway on a 4..20 mA live zero
		currentMode = 1'b1;
		liveZero4mA = 1'b1;
		milliVolts = 16'h1770;
		loadParam(100, -200, 1'b1);
		chk("rejected", 17'h0, 17'(paramRejected));
		wt(3);
		chk("ain", 17'h1F4, 17'(ainInternal));
		chk("scaled", 17'h12C, 17'(scaledValue));
		give_verdict();
	end
endmodule // test_pbi_core
